/* File: verilog/fppr_router.sv */
// Function-pin decoder and 32-pin port router of the synthesizer
`timescale 1ns/1ns
`default_nettype none

module fppr_router
    import fppr_pkg::*;
#(
    parameter int DIV = FPPR_SYNC_DIV
)(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [3:0] func_sel_in,
    input wire logic [31:0] port_in,
    output logic [31:0] port_out,
    output logic [31:0] port_oe_n_out,
    input wire logic io_update_in,
    input wire logic [2:0] profile_select_pins_in,
    input wire logic streaming_en_in,
    input wire logic matched_latency_in,
    input wire logic amplitude_keying_enable_in,
    output logic prog_wr_out,
    output logic prog_rd_out,
    output logic prog_wide_out,
    output logic [7:0] prog_addr_out,
    output logic [15:0] prog_wdata_out,
    input wire logic [15:0] prog_rdata_in,
    output logic ser_cs_n_out,
    output logic ser_sclk_out,
    output logic serial_resync_input_out,
    output logic ser_sdio_out,
    input wire logic ser_sdio_drv_in,
    input wire logic ser_sdio_oe_in,
    input wire logic serial_data_output_in,
    output logic [31:0] freq_tuning_word_out,
    output logic [15:0] phase_offset_word_out,
    output logic [15:0] amplitude_scale_word_out,
    output logic [31:0] core_ftw_out,
    output logic [15:0] core_pow_out,
    output logic [11:0] core_amp_out
);
    // True for the codes that give direct parameter access
    function automatic logic is_direct(input logic [3:0] code);
        is_direct = (code >= FPPR_FS_FTW_STR) && (code <= FPPR_FS_LO_POWL);
    endfunction : is_direct

    logic tick;
    logic [3:0] func_s1_q, func_s2_q;
    logic [31:0] port_s1_q, port_s2_q;
    logic upd_s1_q, upd_s2_q, upd_s3_q;
    logic [2:0] prof_s1_q, prof_s2_q, prof_s3_q;
    logic [3:0] code_q;
    logic [31:0] data_q;
    logic smp_vld_q;
    logic [31:0] ftw_q;
    logic [15:0] pow_q, amp_q;
    logic upd_pend_q;
    logic xfer_q;
    logic [2:0] xfer_sr_q;
    logic [31:0] snap_ftw_q;
    logic [15:0] snap_pow_q;
    logic [11:0] snap_amp_q;
    logic [31:0] core_ftw_q;
    logic [15:0] core_pow_q;
    logic [11:0] core_amp_q;
    logic wr_s3_q, rd_s3_q;
    logic par_mode, ser_mode, upd_evt, xfer_now, ftw_go, pow_go;

    fppr_sync_div #(
        .DIV(DIV)
    ) u_div (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .tick_out(tick)
    );

    // Two-flop synchronisers on every pin input from the controller
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            func_s1_q <= 4'hF;
            func_s2_q <= 4'hF;
            port_s1_q <= 32'h0000_0000;
            port_s2_q <= 32'h0000_0000;
            upd_s1_q <= 1'b0;
            upd_s2_q <= 1'b0;
            prof_s1_q <= 3'h0;
            prof_s2_q <= 3'h0;
        end
        else
        begin
            func_s1_q <= func_sel_in;
            func_s2_q <= func_s1_q;
            port_s1_q <= port_in;
            port_s2_q <= port_s1_q;
            upd_s1_q <= io_update_in;
            upd_s2_q <= upd_s1_q;
            prof_s1_q <= profile_select_pins_in;
            prof_s2_q <= prof_s1_q;
        end
    end

    assign par_mode = (func_s2_q == FPPR_FS_PAR);
    assign ser_mode = (func_s2_q == FPPR_FS_SER);

    // Code and port captured together at each sync edge
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            code_q <= 4'hF;
            data_q <= 32'h0000_0000;
            smp_vld_q <= 1'b0;
        end
        else
        begin
            smp_vld_q <= tick;
            if (tick)
            begin
                code_q <= func_s2_q;
                data_q <= port_s2_q;
            end
        end
    end

    // Byte routing into the parameter registers; 1110/1111 touch nothing
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ftw_q <= FPPR_FTW_RST;
            pow_q <= FPPR_POW_RST;
            amp_q <= FPPR_AMP_RST;
        end
        else if (smp_vld_q)
        begin
            case (code_q)
                FPPR_FS_FTW_STR: ftw_q <= data_q;
                FPPR_FS_FTW_SWP: ftw_q <= {data_q[15:0], data_q[31:16]};
                FPPR_FS_POW_AMP:
                begin
                    pow_q <= data_q[31:16];
                    amp_q <= {4'h0, data_q[11:8], data_q[7:0]};
                end
                FPPR_FS_AMP_POW:
                begin
                    amp_q <= {4'h0, data_q[27:24], data_q[23:16]};
                    pow_q <= data_q[15:0];
                end
                FPPR_FS_HI_AMPH:
                begin
                    ftw_q[31:8] <= data_q[31:8];
                    amp_q[15:8] <= {4'h0, data_q[3:0]};
                end
                FPPR_FS_HI_POWH:
                begin
                    ftw_q[31:8] <= data_q[31:8];
                    pow_q[15:8] <= data_q[7:0];
                end
                FPPR_FS_HI_AMPL:
                begin
                    ftw_q[31:8] <= data_q[31:8];
                    amp_q[7:0] <= data_q[7:0];
                end
                FPPR_FS_HI_POWL:
                begin
                    ftw_q[31:8] <= data_q[31:8];
                    pow_q[7:0] <= data_q[7:0];
                end
                FPPR_FS_LO_AMPH:
                begin
                    ftw_q[23:0] <= data_q[31:8];
                    amp_q[15:8] <= {4'h0, data_q[3:0]};
                end
                FPPR_FS_LO_POWH:
                begin
                    ftw_q[23:0] <= data_q[31:8];
                    pow_q[15:8] <= data_q[7:0];
                end
                FPPR_FS_LO_AMPL:
                begin
                    ftw_q[23:0] <= data_q[31:8];
                    amp_q[7:0] <= data_q[7:0];
                end
                FPPR_FS_LO_POWL:
                begin
                    ftw_q[23:0] <= data_q[31:8];
                    pow_q[7:0] <= data_q[7:0];
                end
                default:
                begin
                    ftw_q <= ftw_q;
                end
            endcase
        end
    end

    // Update pin edge and profile change are the same event
    assign upd_evt = (upd_s2_q && !upd_s3_q) || (prof_s2_q != prof_s3_q);

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            upd_s3_q <= 1'b0;
            prof_s3_q <= 3'h0;
            upd_pend_q <= 1'b0;
        end
        else
        begin
            upd_s3_q <= upd_s2_q;
            prof_s3_q <= prof_s2_q;
            // A new event in the consuming cycle stays pending
            if (upd_evt)
                upd_pend_q <= 1'b1;
            else if (tick)
                upd_pend_q <= 1'b0;
        end
    end

    // Streaming transfer one cycle after routing so the new sample is included; update transfer snapshots in the routing cycle
    assign xfer_now = (tick && upd_pend_q) ||
        (smp_vld_q && streaming_en_in && is_direct(code_q));

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            xfer_q <= 1'b0;
        else
            xfer_q <= xfer_now;
    end

    // Snapshot, then stagger or align the three paths into the core
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            xfer_sr_q <= 3'h0;
            snap_ftw_q <= FPPR_FTW_RST;
            snap_pow_q <= FPPR_POW_RST;
            snap_amp_q <= 12'h000;
        end
        else
        begin
            xfer_sr_q <= {xfer_sr_q[1:0], xfer_q};
            if (xfer_q)
            begin
                snap_ftw_q <= ftw_q;
                snap_pow_q <= pow_q;
                snap_amp_q <= amp_q[11:0];
            end
        end
    end

    assign ftw_go = matched_latency_in ? xfer_sr_q[FPPR_LAT_AMP] : xfer_sr_q[FPPR_LAT_FTW];
    assign pow_go = matched_latency_in ? xfer_sr_q[FPPR_LAT_AMP] : xfer_sr_q[FPPR_LAT_POW];

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            core_ftw_q <= FPPR_FTW_RST;
            core_pow_q <= FPPR_POW_RST;
            core_amp_q <= 12'h000;
        end
        else
        begin
            if (ftw_go)
                core_ftw_q <= snap_ftw_q;
            if (pow_go)
                core_pow_q <= snap_pow_q;
            // Amplitude from the port only counts with keying enabled
            if (xfer_sr_q[FPPR_LAT_AMP] && amplitude_keying_enable_in)
                core_amp_q <= snap_amp_q;
        end
    end

    // Parallel programming strobes from control pin rising edges
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_s3_q <= 1'b0;
            rd_s3_q <= 1'b0;
            prog_wr_out <= 1'b0;
            prog_rd_out <= 1'b0;
            prog_wide_out <= 1'b0;
            prog_addr_out <= 8'h00;
            prog_wdata_out <= 16'h0000;
        end
        else
        begin
            wr_s3_q <= port_s2_q[FPPR_CTL_WR];
            rd_s3_q <= port_s2_q[FPPR_CTL_RD];
            // One strobe per write edge: no rate limit inside the router
            prog_wr_out <= par_mode && port_s2_q[FPPR_CTL_WR] && !wr_s3_q;
            prog_rd_out <= par_mode && port_s2_q[FPPR_CTL_RD] && !rd_s3_q;
            prog_wide_out <= port_s2_q[FPPR_CTL_WIDE];
            prog_addr_out <= port_s2_q[15:8];
            prog_wdata_out <= port_s2_q[FPPR_CTL_WIDE] ? port_s2_q[31:16] :
                {8'h00, port_s2_q[23:16]};
        end
    end

    // Pin drivers: read data in parallel mode, serial data lines in serial mode
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            port_out <= 32'h0000_0000;
            port_oe_n_out <= 32'hFFFF_FFFF;
        end
        else
        begin
            port_out <= 32'h0000_0000;
            port_oe_n_out <= 32'hFFFF_FFFF;
            if (par_mode && port_s2_q[FPPR_CTL_RD])
            begin
                port_out[31:16] <= port_s2_q[FPPR_CTL_WIDE] ? prog_rdata_in :
                    {8'h00, prog_rdata_in[7:0]};
                port_oe_n_out[31:24] <= {8{!port_s2_q[FPPR_CTL_WIDE]}};
                port_oe_n_out[23:16] <= 8'h00;
            end
            else if (ser_mode)
            begin
                port_out[FPPR_SER_SDO] <= serial_data_output_in;
                port_oe_n_out[FPPR_SER_SDO] <= 1'b0;
                port_out[FPPR_SER_SDIO] <= ser_sdio_drv_in;
                port_oe_n_out[FPPR_SER_SDIO] <= !ser_sdio_oe_in;
            end
        end
    end

    // Serial pins only pass in serial mode; upper pins are ignored there
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ser_cs_n_out <= 1'b1;
            ser_sclk_out <= 1'b0;
            serial_resync_input_out <= 1'b0;
            ser_sdio_out <= 1'b0;
        end
        else
        begin
            ser_cs_n_out <= ser_mode ? port_s2_q[FPPR_SER_CS] : 1'b1;
            ser_sclk_out <= ser_mode && port_s2_q[FPPR_SER_SCLK];
            serial_resync_input_out <= ser_mode && port_s2_q[FPPR_SER_RESYNC];
            ser_sdio_out <= ser_mode && port_s2_q[FPPR_SER_SDIO];
        end
    end

    assign freq_tuning_word_out = ftw_q;
    assign phase_offset_word_out = pow_q;
    assign amplitude_scale_word_out = amp_q;
    assign core_ftw_out = core_ftw_q;
    assign core_pow_out = core_pow_q;
    assign core_amp_out = core_amp_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_straight_ftw: assert property (smp_vld_q && code_q == FPPR_FS_FTW_STR |=> ftw_q == $past(data_q))
        else $error("straight frequency load wrong");
    a_swap_ftw: assert property (smp_vld_q && code_q == FPPR_FS_FTW_SWP |=>
        ftw_q[31:16] == $past(data_q[15:0]) && ftw_q[15:0] == $past(data_q[31:16]))
        else $error("swapped frequency load wrong");
    a_pow_amp_split: assert property (smp_vld_q && code_q == FPPR_FS_POW_AMP |=>
        pow_q == $past(data_q[31:16]) && amp_q[11:0] == $past(data_q[11:0]))
        else $error("phase/amplitude split wrong");
    a_amp_pow_split: assert property (smp_vld_q && code_q == FPPR_FS_AMP_POW |=>
        pow_q == $past(data_q[15:0]) && amp_q[11:0] == $past(data_q[27:16]))
        else $error("amplitude/phase split wrong");
    a_amp_top_zero: assert property (amp_q[15:12] == 4'h0)
        else $error("amplitude upper bits used");
    a_unused_hold: assert property (smp_vld_q && code_q >= 4'hE |=> $stable(ftw_q) && $stable(pow_q))
        else $error("unused code changed parameters");
    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("sync tick too frequent");
    a_stream_xfer: assert property (smp_vld_q && streaming_en_in && is_direct(code_q) && !matched_latency_in
        |=> ##2 core_ftw_q == $past(ftw_q))
        else $error("streaming did not reach core");
    a_no_stray_xfer: assert property (xfer_now && !smp_vld_q |-> tick && upd_pend_q)
        else $error("core updated without update event");
    // Back-to-back transfers overlap in the pipeline, so only a lone one is followed
    a_matched_align: assert property (matched_latency_in && xfer_q && !xfer_now && !$past(xfer_q)
        |=> ##1 $stable(core_ftw_q) && $stable(core_pow_q)
        ##1 $stable(core_ftw_q) && $stable(core_pow_q)
        ##1 core_ftw_q == $past(snap_ftw_q) && core_pow_q == $past(snap_pow_q))
        else $error("matched latency paths misaligned");
    a_wr_strobe: assert property (prog_wr_out |=> !prog_wr_out)
        else $error("write strobe longer than one cycle");
    a_ser_quiet: assert property (!ser_mode |=> ser_cs_n_out)
        else $error("serial select active outside serial mode");

    c_stream: cover property (streaming_en_in && xfer_now && smp_vld_q);
    c_update: cover property (upd_evt ##[1:30] xfer_now);
    c_par_write: cover property (prog_wr_out && prog_wide_out);
    c_ser_mode: cover property (ser_mode && !ser_cs_n_out);
endmodule : fppr_router

`default_nettype wire

/* File: verilog/fppr_pkg_div.sv */
// Constants package and sync-clock enable divider for the function-pin port router
// Behaviour
// - Code 0000 opens register programming bus
// - Parallel mode: data 31:16, address 15:8, control 2:0
// - Control pins pick read/write and 16/8-bit data
// - Code 0001: serial mode, only pins 4:0 used
// - Serial pins: select, clock, resync, data, output
// - Codes 0010-1101 direct access; 1110/1111 ignored
// - Code 0010 loads frequency word straight
// - Code 0011 loads frequency word with its 16-bit halves swapped
// - Code 0100: phase high half, amplitude low
// - Code 0101: amplitude high half, phase low
// - Codes 0110-1001: frequency 31:8 plus byte
// - Codes 1010-1101: frequency 23:0 plus byte
// - Only amplitude bits 11:0 are used
// - Port sampled once per 24 system clocks
// - Parallel writes at full documented byte rate
// - Without streaming, core waits for update pin
// - Streaming pushes port data every sync edge of a direct-access code
// - Matched-latency bit equalises core delays
// - Update pulse equals profile change, sync-gated
package fppr_pkg;
    localparam int FPPR_SYNC_DIV = 24;
    localparam int FPPR_DIV_W = 5;
    localparam logic [3:0] FPPR_FS_PAR = 4'h0;
    localparam logic [3:0] FPPR_FS_SER = 4'h1;
    localparam logic [3:0] FPPR_FS_FTW_STR = 4'h2;
    localparam logic [3:0] FPPR_FS_FTW_SWP = 4'h3;
    localparam logic [3:0] FPPR_FS_POW_AMP = 4'h4;
    localparam logic [3:0] FPPR_FS_AMP_POW = 4'h5;
    localparam logic [3:0] FPPR_FS_HI_AMPH = 4'h6;
    localparam logic [3:0] FPPR_FS_HI_POWH = 4'h7;
    localparam logic [3:0] FPPR_FS_HI_AMPL = 4'h8;
    localparam logic [3:0] FPPR_FS_HI_POWL = 4'h9;
    localparam logic [3:0] FPPR_FS_LO_AMPH = 4'hA;
    localparam logic [3:0] FPPR_FS_LO_POWH = 4'hB;
    localparam logic [3:0] FPPR_FS_LO_AMPL = 4'hC;
    localparam logic [3:0] FPPR_FS_LO_POWL = 4'hD;
    // Parallel control pin positions
    localparam int FPPR_CTL_WIDE = 0;
    localparam int FPPR_CTL_RD = 1;
    localparam int FPPR_CTL_WR = 2;
    // Serial pin positions
    localparam int FPPR_SER_CS = 0;
    localparam int FPPR_SER_SCLK = 1;
    localparam int FPPR_SER_SDIO = 2;
    localparam int FPPR_SER_SDO = 3;
    localparam int FPPR_SER_RESYNC = 4;
    // Extra system clocks to core per parameter when latency is not matched
    localparam int FPPR_LAT_FTW = 0;
    localparam int FPPR_LAT_POW = 1;
    localparam int FPPR_LAT_AMP = 2;
    localparam logic [31:0] FPPR_FTW_RST = 32'h0000_0000;
    localparam logic [15:0] FPPR_POW_RST = 16'h0000;
    localparam logic [15:0] FPPR_AMP_RST = 16'h0000;
endpackage : fppr_pkg

`timescale 1ns/1ns
`default_nettype none

module fppr_sync_div
    import fppr_pkg::*;
#(
    parameter int DIV = FPPR_SYNC_DIV
)(
    input wire logic clk_in,
    input wire logic arst_n_in,
    output logic tick_out
);
    logic [FPPR_DIV_W-1:0] cnt_q;

    // Free-running count; tick marks the internal sync clock edge
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cnt_q <= '0;
        else if (cnt_q == FPPR_DIV_W'(DIV - 1))
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + 1'b1;
    end

    assign tick_out = (cnt_q == FPPR_DIV_W'(DIV - 1));
endmodule : fppr_sync_div

`default_nettype wire

/* File: verification/fppr_ctl_model.sv */
// Controller model that drives the function pins and the 32-pin port
`timescale 1ns/1ns
`default_nettype none

module fppr_ctl_model
    import fppr_pkg::*;
(
    input wire logic clk_in,
    input wire logic [31:0] port_out_in,
    input wire logic [31:0] port_oe_n_in,
    output logic [3:0] func_sel_out,
    output logic [31:0] pins_out
);
    logic [31:0] drv_q = 32'h0000_0000;
    logic [31:0] en_q = 32'hFFFF_FFFF;
    logic [31:0] float_q = 32'h5555_5555;
    logic [3:0] func_q = 4'hF;

    // A released line has no pull, so it must not keep its last value
    always @(posedge clk_in)
    begin
        float_q <= ~float_q;
    end

    // Pin level from both parties' enables
    assign pins_out = (~port_oe_n_in & port_out_in) | (port_oe_n_in & en_q & drv_q)
        | (port_oe_n_in & ~en_q & float_q);
    assign func_sel_out = func_q;

    // Pins change just after an edge and stand until the next call
    task automatic drive(input logic [3:0] code, input logic [31:0] val, input logic [31:0] en);
        @(posedge clk_in);
        func_q <= code;
        drv_q <= val;
        en_q <= en;
    endtask : drive

    // Register cycle: data 31:16, address 15:8, write/read/width on 2:0
    task automatic reg_cycle(input logic wr, input logic rd, input logic wide,
        input logic [7:0] addr, input logic [15:0] data);
        drive(4'h0, {data, addr, 8'h00} | {31'h0, wide}, 32'hFFFF_FFFF);
        repeat (4) @(posedge clk_in);
        // Data pins released while the device answers a read
        drive(4'h0, {data, addr, 5'h00, wr, rd, wide}, rd ? 32'h0000_FFFF : 32'hFFFF_FFFF);
        repeat (8) @(posedge clk_in);
        drive(4'h0, {data, addr, 8'h00} | {31'h0, wide}, 32'hFFFF_FFFF);
    endtask : reg_cycle
endmodule : fppr_ctl_model

`default_nettype wire

/* File: verification/fppr_router_tb.sv */
// Self-checking bench for the function-pin port router
`timescale 1ns/1ns
`default_nettype none

module fppr_router_tb
    import fppr_pkg::*;
;
    localparam int DIV_T = 12;
    localparam int SETTLE = 2 * DIV_T + 8;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [3:0] func_sel;
    logic [31:0] pins, port_out, oe_n, freq_tuning_word, c_ftw;
    logic io_upd = 1'b0, strm = 1'b1, mlat = 1'b1, sd_drv = 1'b0, sd_oe = 1'b0, serial_data_output = 1'b0;
    logic amp_en = 1'b1;
    logic [2:0] prof = 3'h0;
    logic [15:0] rdata = 16'h0000, wdata, phase_offset_word, amplitude_scale_word, c_pow;
    logic [7:0] addr;
    logic [11:0] c_amp, e_amp = 12'h000;
    logic wr_o, rd_o, wide_o, cs_n_o, sclk_o, rsync_o, sdio_o;
    logic [31:0] m_ftw = 32'h0, e_ftw = 32'h0;
    logic [15:0] m_pow = 16'h0, m_amp = 16'h0, e_pow = 16'h0;
    int num_errors = 0;
    int compares = 0;

    // 100 MHz clock
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    fppr_ctl_model ctl (.clk_in(clk_in), .port_out_in(port_out), .port_oe_n_in(oe_n),
        .func_sel_out(func_sel), .pins_out(pins));

    fppr_router #(.DIV(DIV_T)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .func_sel_in(func_sel), .port_in(pins), .port_out(port_out), .port_oe_n_out(oe_n),
        .io_update_in(io_upd), .profile_select_pins_in(prof), .streaming_en_in(strm),
        .matched_latency_in(mlat), .amplitude_keying_enable_in(amp_en), .prog_wr_out(wr_o),
        .prog_rd_out(rd_o), .prog_wide_out(wide_o), .prog_addr_out(addr),
        .prog_wdata_out(wdata), .prog_rdata_in(rdata), .ser_cs_n_out(cs_n_o),
        .ser_sclk_out(sclk_o), .serial_resync_input_out(rsync_o), .ser_sdio_out(sdio_o),
        .ser_sdio_drv_in(sd_drv), .ser_sdio_oe_in(sd_oe), .serial_data_output_in(serial_data_output),
        .freq_tuning_word_out(freq_tuning_word), .phase_offset_word_out(phase_offset_word),
        .amplitude_scale_word_out(amplitude_scale_word), .core_ftw_out(c_ftw), .core_pow_out(c_pow),
        .core_amp_out(c_amp));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // Reference routing of one sampled word into the parameter registers
    task automatic model_apply(input logic [3:0] c, input logic [31:0] d);
        if (c == 4'h2)
            m_ftw = d;
        else if (c == 4'h3)
            m_ftw = {d[15:0], d[31:16]};
        else if (c == 4'h4)
            {m_pow, m_amp} = {d[31:16], 4'h0, d[11:0]};
        else if (c == 4'h5)
            {m_amp, m_pow} = {4'h0, d[27:16], d[15:0]};
        else if (c >= 4'h6 && c <= 4'hD)
        begin
            if (c <= 4'h9)
                m_ftw[31:8] = d[31:8];
            else
                m_ftw[23:0] = d[31:8];
            case (c[1:0])
                2'b10: m_amp[11:8] = d[3:0];
                2'b11: m_pow[15:8] = d[7:0];
                2'b00: m_amp[7:0] = d[7:0];
                default: m_pow[7:0] = d[7:0];
            endcase
        end
    endtask : model_apply

    // Core copy; amplitude only moves while its enable is set
    task automatic model_xfer();
        e_ftw = m_ftw;
        e_pow = m_pow;
        if (amp_en)
            e_amp = m_amp[11:0];
    endtask : model_xfer

    task automatic check_all();
        @(negedge clk_in);
        check(freq_tuning_word, m_ftw);
        check({phase_offset_word, amplitude_scale_word}, {m_pow, m_amp});
        check(c_ftw, e_ftw);
        check({c_pow, 4'h0, c_amp}, {e_pow, 4'h0, e_amp});
    endtask : check_all

    // One direct-access sample held across at least one sync tick
    task automatic direct(input logic [3:0] c, input logic [31:0] d);
        ctl.drive(c, d, 32'hFFFF_FFFF);
        model_apply(c, d);
        if (strm)
            model_xfer();
        repeat (SETTLE) @(posedge clk_in);
        check_all();
    endtask : direct

    // Register cycle watched at every cycle for strobe count and fields
    task automatic reg_test(input logic rd, input logic wide, input logic [31:0] r);
        int nwr;
        int nrd;
        logic [31:0] cap_p;
        logic [31:0] cap_o;
        logic [31:0] exp_oe;
        nwr = 0;
        nrd = 0;
        exp_oe = !rd ? 32'hFFFF_FFFF : (wide ? 32'h0000_FFFF : 32'hFF00_FFFF);
        fork
            ctl.reg_cycle(!rd, rd, wide, r[7:0], r[31:16]);
            for (int i = 0; i < 18; i++)
            begin
                @(negedge clk_in);
                nwr += int'(wr_o === 1'b1);
                nrd += int'(rd_o === 1'b1);
                if (i == 11)
                begin
                    check({wide_o, addr}, {wide, r[7:0]});
                    // On a read the upper pins carry the device's own read data
                    check(wdata, rd ? (wide ? rdata : {8'h00, rdata[7:0]}) :
                        (wide ? r[31:16] : {8'h00, r[23:16]}));
                    {cap_p, cap_o} = {port_out, oe_n};
                end
            end
        join
        check(nwr, 32'(!rd));
        check(nrd, 32'(rd));
        check(cap_o, exp_oe);
        check(cap_p & ~exp_oe, rd ? (wide ? {rdata, 16'h0} : {8'h0, rdata[7:0], 16'h0}) :
            32'h0);
    endtask : reg_test

    // Main sequence
    initial
    begin
        logic [31:0] v;
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(negedge clk_in);
        check(oe_n, 32'hFFFF_FFFF);
        check({cs_n_o, wr_o}, 32'h2);
        check(freq_tuning_word, 32'h0);
        void'($urandom(32'h3248));
        for (int r = 0; r < 2; r++)
        begin
            for (int c = 2; c < 16; c++)
                direct(4'(c), $urandom());
            @(posedge clk_in);
            mlat <= 1'b0;
        end
        @(posedge clk_in);
        strm <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            direct(4'(2 + ($urandom() % 12)), $urandom());
            @(posedge clk_in);
            if (k[0])
                prof <= prof + 3'h1;
            else
                io_upd <= 1'b1;
            repeat (3) @(posedge clk_in);
            io_upd <= 1'b0;
            model_xfer();
            repeat (SETTLE) @(posedge clk_in);
            check_all();
        end
        @(posedge clk_in);
        amp_en <= 1'b0;
        strm <= 1'b1;
        rdata <= 16'($urandom());
        direct(4'h5, $urandom());
        direct(4'h4, $urandom());
        for (int k = 0; k < 4; k++)
            reg_test(k[1], k[0], $urandom());
        for (int k = 0; k < 4; k++)
        begin
            v = $urandom();
            // Each level held 20 cycles keeps the serial rate under 3 Mbps
            ctl.drive(4'h1, v, v[7] ? 32'hFFFF_FFF3 : 32'hFFFF_FFF7);
            {sd_oe, sd_drv, serial_data_output} <= v[7:5];
            repeat (20) @(posedge clk_in);
            @(negedge clk_in);
            check({cs_n_o, sclk_o, rsync_o, port_out[3]}, {v[0], v[1], v[4], v[5]});
            check(oe_n, v[7] ? 32'hFFFF_FFF3 : 32'hFFFF_FFF7);
            check(v[7] ? port_out[2] : sdio_o, v[7] ? v[6] : v[2]);
        end
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (10000) @(posedge clk_in);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule : fppr_router_tb

`default_nettype wire
